// [bench/peer_node_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ***********************************
// Far-side peer node on the segment
// ***********************************
module peer_node_model
(
   // Clock and pacing
   input  wire logic                     clk_i,
   input  wire logic                     slow_i,
   // Broadcasts leaving the device
   input  wire logic                     tx_valid_i,
   input  wire peer_xchg_pkg::peer_hdr_t tx_hdr_i,
   input  wire logic [15:0]              tx_data_i,
   input  wire logic                     tx_last_i,
   output logic                          tx_ready_o,
   // Broadcasts reaching the device
   output logic                          rx_valid_o,
   output peer_xchg_pkg::peer_hdr_t      rx_hdr_o,
   output logic [15:0]                   rx_data_o,
   output logic                          rx_last_o
);
   logic [15:0]              beats[$];
   peer_xchg_pkg::peer_hdr_t first_hdr;
   int                       frames;

   initial
   begin
      tx_ready_o = 1'b1;
      rx_valid_o = 1'b0;
      rx_hdr_o   = '0;
      rx_data_o  = 16'h0000;
      rx_last_o  = 1'b0;
      frames     = 0;
   end

   // Slow mode stalls every other cycle; no reply is ever sent back
   always @(posedge clk_i)
   begin
      if (tx_valid_i && tx_ready_o)
      begin
         if (beats.size() == 0)
            first_hdr = tx_hdr_i;
         beats.push_back(tx_data_i);
         if (tx_last_i)
            frames++;
      end
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
   end

   // One frame, header held on every beat, dest chosen by the sender
   task automatic send_frame(input logic [7:0] node, input logic [15:0] dest,
                             input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_hdr_o   <= '{node: node, dest: dest, count: n[7:0]};
         rx_data_o  <= base + i[15:0];
         rx_last_o  <= (i == n - 1);
      end
      // Released lines show a changed pattern, not the last beat
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_last_o  <= 1'b0;
      rx_data_o  <= ~rx_data_o;
      rx_hdr_o   <= ~rx_hdr_o;
   endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic                     clk, resetn, wr, rd, col, slow;
   logic [15:0]              addr, wdata, rdata, txd, rxd;
   logic                     txv, txl, txr, rxv, rxl;
   peer_xchg_pkg::peer_hdr_t txh, rxh;
   int                       failures = 0;
   int                       checks = 0;
   int                       n;

   // ***********************************
   // Clock, device and partner
   // ***********************************
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Short millisecond keeps slot and loss timing inside the run
   peer_xchg #(.MS_CYCLES(10)) DUT (.CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr),
      .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .TX_VALID_O(txv),
      .TX_HDR_O(txh), .TX_DATA_O(txd), .TX_LAST_O(txl), .TX_READY_I(txr),
      .RX_VALID_I(rxv), .RX_HDR_I(rxh), .RX_DATA_I(rxd), .RX_LAST_I(rxl),
      .COLLISION_I(col));

   peer_node_model peer (.clk_i(clk), .slow_i(slow), .tx_valid_i(txv), .tx_hdr_i(txh),
      .tx_data_i(txd), .tx_last_i(txl), .tx_ready_o(txr), .rx_valid_o(rxv),
      .rx_hdr_o(rxh), .rx_data_o(rxd), .rx_last_o(rxl));

   // ***********************************
   // Access and compare tasks
   // ***********************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog sized well past the whole sequence
   initial
   begin
      #200000;
      failures++;
      tally_and_finish();
   end

   // ***********************************
   // Test sequence
   // ***********************************
   initial
   begin
      resetn = 1'b0;
      {wr, rd, col, slow} = 4'h0;
      addr = 16'h0000;
      wdata = 16'h0000;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      // Setup registers clear, read-only and unmapped places
      rd_chk("interval", peer_xchg_pkg::ADDR_INTERVAL, 16'h0000);
      rd_chk("feature", peer_xchg_pkg::ADDR_FEATURE, 16'h0000);
      wr_reg(peer_xchg_pkg::ADDR_ACTIVE, 16'hFFFF);
      rd_chk("active ro", peer_xchg_pkg::ADDR_ACTIVE, 16'h0000);
      rd_chk("unmapped", 16'h2000, 16'h0000);
      $display("test registers done");

      // Own broadcast, node 1 of 2, three words, receiver stalling
      for (int i = 0; i < 3; i++)
         wr_reg(16'h0010 + i[15:0], 16'hA000 + i[15:0]);
      slow <= 1'b1;
      wr_reg(peer_xchg_pkg::ADDR_INTERVAL, 16'h0002);
      wr_reg(peer_xchg_pkg::ADDR_OWN_NODE, 16'h0001);
      wr_reg(peer_xchg_pkg::ADDR_NODE_TOTAL, 16'h0002);
      wr_reg(peer_xchg_pkg::ADDR_TX_START, 16'h0010);
      wr_reg(peer_xchg_pkg::ADDR_TX_LENGTH, 16'h0003);
      wr_reg(peer_xchg_pkg::ADDR_DEST_START, 16'h0020);
      wr_reg(peer_xchg_pkg::ADDR_FEATURE, 16'h0040);
      for (int i = 0; i < 300 && peer.frames == 0; i++)
         @(posedge clk);
      chk("frames", 16'h0001, (peer.frames > 0) ? 16'h0001 : 16'h0000);
      for (int i = 0; i < 3; i++)
         chk("tx word", 16'hA000 + i[15:0], peer.beats[i]);
      chk("tx node", 16'h0001, {8'h00, peer.first_hdr.node});
      chk("tx dest", 16'h0020, peer.first_hdr.dest);
      chk("tx count", 16'h0003, {8'h00, peer.first_hdr.count});
      $display("test transmit done");

      // Peer 2 heard, peer 17 has no flag, then peer 2 falls silent
      peer.send_frame(8'h02, 16'h0030, 2, 16'hB000);
      peer.send_frame(8'h11, 16'h0050, 1, 16'hB100);
      rd_chk("rx word0", 16'h0030, 16'hB000);
      rd_chk("rx word1", 16'h0031, 16'hB001);
      rd_chk("active", peer_xchg_pkg::ADDR_ACTIVE, 16'h0002);
      rd_chk("rx frames", peer_xchg_pkg::ADDR_PKT_B, 16'h0002);
      // Software write meets a peer beat; peer word kept, ours lands later
      fork
         peer.send_frame(8'h02, 16'h0060, 2, 16'hD000);
         wr_reg(16'h0070, 16'h1111);
      join
      rd_chk("prio word0", 16'h0060, 16'hD000);
      rd_chk("prio word1", 16'h0061, 16'hD001);
      rd_chk("deferred", 16'h0070, 16'h1111);
      repeat (100) @(posedge clk);
      rd_chk("active lost", peer_xchg_pkg::ADDR_ACTIVE, 16'h0000);
      $display("test receive done");

      // Disabled node neither sends nor stores
      wr_reg(peer_xchg_pkg::ADDR_FEATURE, 16'h0000);
      repeat (30) @(posedge clk);
      n = peer.frames;
      rd_chk("tx frames", peer_xchg_pkg::ADDR_PKT_A, n[15:0]);
      wr_reg(16'h0040, 16'h1234);
      peer.send_frame(8'h02, 16'h0040, 1, 16'hC000);
      rd_chk("ignored", 16'h0040, 16'h1234);
      repeat (60) @(posedge clk);
      chk("quiet", n[15:0], peer.frames[15:0]);
      $display("test disable done");

      // Listen-only node stores but stays silent
      wr_reg(peer_xchg_pkg::ADDR_OWN_NODE, 16'h0000);
      wr_reg(peer_xchg_pkg::ADDR_FEATURE, 16'h0040);
      peer.send_frame(8'h02, 16'h0040, 1, 16'hC000);
      rd_chk("listen", 16'h0040, 16'hC000);
      repeat (60) @(posedge clk);
      chk("listen quiet", n[15:0], peer.frames[15:0]);
      $display("test listen done");

      // Two line collisions counted
      repeat (2)
      begin
         @(posedge clk);
         col <= 1'b1;
         @(posedge clk);
         col <= 1'b0;
      end
      rd_chk("collisions", peer_xchg_pkg::ADDR_COLL_A, 16'h0002);
      rd_chk("own frames hit", peer_xchg_pkg::ADDR_COLL_B, 16'h0000);
      $display("test collision done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// [rtl/peer_xchg.sv]
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module peer_xchg
#(
   parameter int MS_CYCLES = peer_xchg_pkg::MS_CYCLES
)
(
   // Clock and reset
   input  wire logic                     CLK_I,
   input  wire logic                     RESETN_I,
   // Register port
   input  wire logic [15:0]              ADDR_I,
   input  wire logic [15:0]              WR_DATA_I,
   input  wire logic                     WR_I,
   input  wire logic                     RD_I,
   output logic [15:0]                   RD_DATA_O,
   // Broadcast transmit stream
   output logic                          TX_VALID_O,
   output peer_xchg_pkg::peer_hdr_t      TX_HDR_O,
   output logic [15:0]                   TX_DATA_O,
   output logic                          TX_LAST_O,
   input  wire logic                     TX_READY_I,
   // Broadcast receive stream
   input  wire logic                     RX_VALID_I,
   input  wire peer_xchg_pkg::peer_hdr_t RX_HDR_I,
   input  wire logic [15:0]              RX_DATA_I,
   input  wire logic                     RX_LAST_I,
   // Line events
   input  wire logic                     COLLISION_I
);

   // ***********************************
   // Declarations
   // ***********************************
   logic [15:0] mbox [0:2047];
   logic [15:0] interval;
   logic [15:0] own_node;
   logic [15:0] tx_block_start;
   logic [15:0] node_total;
   logic [15:0] tx_length;
   logic [15:0] dest_start;
   logic [15:0] feature;
   logic [15:0] pkt_tx;
   logic [15:0] pkt_rx;
   logic [15:0] coll;
   logic [15:0] coll_frames;
   logic [15:0] active;
   logic [15:0] age [0:15];
   logic [peer_xchg_pkg::TICK_W-1:0] tick_cnt;
   logic        ms_tick;
   logic [15:0] ms_count;
   logic [15:0] slot_ms;
   peer_xchg_pkg::tx_state_t state;
   peer_xchg_pkg::tx_state_t next_state;
   logic [10:0] tx_base;
   logic [7:0]  tx_idx;
   logic        tx_start;
   logic        tx_fire;
   logic        tx_hit;
   logic        enable;
   logic [10:0] rx_idx;
   logic        rx_we;
   logic [10:0] rx_addr;
   logic        bus_mbox;
   logic        bus_mbox_we;
   logic        pend_v;
   logic [10:0] pend_addr;
   logic [15:0] pend_data;
   logic        mb_we;
   logic [10:0] mb_addr;
   logic [15:0] mb_data;
   logic        mb_from_rx;

   // ***********************************
   // Helpers
   // ***********************************
   // Mailbox word index from a 1-based register number
   function automatic logic [10:0] mbox_idx(input logic [15:0] reg_no);
      logic [15:0] d;
      d = reg_no - 16'h0001;
      return d[10:0];
   endfunction

   // Slot offset in ms; division is slow but only config-driven
   function automatic logic [15:0] slot_of(input logic [15:0] node,
                                           input logic [15:0] ivl,
                                           input logic [15:0] tot);
      logic [31:0] p;
      p = 32'h0000_0000;
      if (tot == 16'h0000 || node == 16'h0000)
         return 16'h0000;
      p = ({16'h0000, node - 16'h0001} * {16'h0000, ivl}) / {16'h0000, tot};
      return p[15:0];
   endfunction

   assign enable   = feature[peer_xchg_pkg::ENABLE_BIT];
   assign bus_mbox = ADDR_I >= peer_xchg_pkg::MBOX_FIRST
                     && ADDR_I <= peer_xchg_pkg::MBOX_LAST;
   assign bus_mbox_we = WR_I && bus_mbox;

   // ***********************************
   // Register writes
   // ***********************************
   // Setup registers, written by software only
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         interval       <= peer_xchg_pkg::REG_RESET;
         own_node       <= peer_xchg_pkg::REG_RESET;
         tx_block_start <= peer_xchg_pkg::REG_RESET;
         node_total     <= peer_xchg_pkg::REG_RESET;
         tx_length      <= peer_xchg_pkg::REG_RESET;
         dest_start     <= peer_xchg_pkg::REG_RESET;
         feature        <= peer_xchg_pkg::REG_RESET;
      end
      else if (WR_I)
      begin
         unique case (ADDR_I)
            peer_xchg_pkg::ADDR_INTERVAL:   interval       <= WR_DATA_I;
            peer_xchg_pkg::ADDR_OWN_NODE:   own_node       <= WR_DATA_I;
            peer_xchg_pkg::ADDR_TX_START:   tx_block_start <= WR_DATA_I;
            peer_xchg_pkg::ADDR_NODE_TOTAL: node_total     <= WR_DATA_I;
            peer_xchg_pkg::ADDR_TX_LENGTH:  tx_length      <= WR_DATA_I;
            peer_xchg_pkg::ADDR_DEST_START: dest_start     <= WR_DATA_I;
            peer_xchg_pkg::ADDR_FEATURE:    feature        <= WR_DATA_I;
            default: ;
         endcase
      end
   end

   // ***********************************
   // Register reads
   // ***********************************
   // Read data valid the cycle after the strobe only
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         RD_DATA_O <= 16'h0000;
      else if (!RD_I)
         RD_DATA_O <= 16'h0000;
      else if (bus_mbox)
         RD_DATA_O <= mbox[mbox_idx(ADDR_I)];
      else
      begin
         unique case (ADDR_I)
            peer_xchg_pkg::ADDR_PKT_A:      RD_DATA_O <= pkt_tx;
            peer_xchg_pkg::ADDR_PKT_B:      RD_DATA_O <= pkt_rx;
            peer_xchg_pkg::ADDR_COLL_A:     RD_DATA_O <= coll;
            peer_xchg_pkg::ADDR_COLL_B:     RD_DATA_O <= coll_frames;
            peer_xchg_pkg::ADDR_ACTIVE:     RD_DATA_O <= active;
            peer_xchg_pkg::ADDR_INTERVAL:   RD_DATA_O <= interval;
            peer_xchg_pkg::ADDR_OWN_NODE:   RD_DATA_O <= own_node;
            peer_xchg_pkg::ADDR_TX_START:   RD_DATA_O <= tx_block_start;
            peer_xchg_pkg::ADDR_NODE_TOTAL: RD_DATA_O <= node_total;
            peer_xchg_pkg::ADDR_TX_LENGTH:  RD_DATA_O <= tx_length;
            peer_xchg_pkg::ADDR_DEST_START: RD_DATA_O <= dest_start;
            peer_xchg_pkg::ADDR_FEATURE:    RD_DATA_O <= feature;
            default:                        RD_DATA_O <= 16'h0000;
         endcase
      end
   end

   // ***********************************
   // Millisecond time base
   // ***********************************
   // Free-running, so losing a peer cannot shift our slot
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         tick_cnt <= '0;
      else if (tick_cnt == peer_xchg_pkg::TICK_W'(MS_CYCLES - 1))
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 1'b1;
   end
   assign ms_tick = tick_cnt == peer_xchg_pkg::TICK_W'(MS_CYCLES - 1);

   // Position inside the update interval, in ms
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         ms_count <= 16'h0000;
      else if (ms_tick)
         ms_count <= (ms_count + 16'h0001 >= interval) ? 16'h0000
                                                       : ms_count + 16'h0001;
   end

   assign slot_ms = slot_of(own_node, interval, node_total);

   // ***********************************
   // Transmit
   // ***********************************
   // Once per interval in our slot; a listener never sends
   assign tx_start = ms_tick && state == peer_xchg_pkg::TX_IDLE
                     && enable && own_node != 16'h0000
                     && interval != 16'h0000
                     && tx_length != 16'h0000
                     && tx_length <= {8'h00, peer_xchg_pkg::TX_LEN_MAX}
                     && ms_count == slot_ms;
   assign tx_fire  = TX_VALID_O && TX_READY_I;

   always_comb
   begin
      next_state = state;
      unique case (state)
         peer_xchg_pkg::TX_IDLE: if (tx_start) next_state = peer_xchg_pkg::TX_SEND;
         peer_xchg_pkg::TX_SEND: if (tx_fire && TX_LAST_O) next_state = peer_xchg_pkg::TX_IDLE;
         default:                next_state = peer_xchg_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         state <= peer_xchg_pkg::TX_IDLE;
      else
         state <= next_state;
   end

   // One multicast frame; header frozen for the whole frame
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         TX_HDR_O  <= '0;
         tx_base   <= 11'h000;
         tx_idx    <= 8'h00;
         TX_DATA_O <= 16'h0000;
      end
      else if (tx_start)
      begin
         TX_HDR_O.node  <= own_node[7:0];
         TX_HDR_O.dest  <= dest_start;
         TX_HDR_O.count <= tx_length[7:0];
         tx_base        <= mbox_idx(tx_block_start);
         tx_idx         <= 8'h00;
         TX_DATA_O      <= mbox[mbox_idx(tx_block_start)];
      end
      else if (tx_fire && !TX_LAST_O)
      begin
         tx_idx    <= tx_idx + 8'h01;
         TX_DATA_O <= mbox[tx_base + {3'b000, tx_idx} + 11'h001];
      end
   end

   assign TX_VALID_O = state == peer_xchg_pkg::TX_SEND;
   assign TX_LAST_O  = TX_VALID_O && tx_idx == TX_HDR_O.count - 8'h01;

   // ***********************************
   // Receive and mailbox arbitration
   // ***********************************
   // Store beats at the sender's destination; no reply is sent
   assign rx_we   = RX_VALID_I && enable
                    && !(own_node != 16'h0000 && RX_HDR_I.node == own_node[7:0]);
   assign rx_addr = mbox_idx(RX_HDR_I.dest) + rx_idx;

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         rx_idx <= 11'h000;
      else if (RX_VALID_I)
         rx_idx <= RX_LAST_I ? 11'h000 : rx_idx + 11'h001;
   end

   // Peer writes win; a colliding software write waits for the first cycle without a peer write
   always_comb
   begin
      mb_we      = 1'b1;
      mb_from_rx = 1'b0;
      mb_addr    = mbox_idx(ADDR_I);
      mb_data    = WR_DATA_I;
      if (rx_we)
      begin
         mb_from_rx = 1'b1;
         mb_addr    = rx_addr;
         mb_data    = RX_DATA_I;
      end
      else if (pend_v)
      begin
         mb_addr = pend_addr;
         mb_data = pend_data;
      end
      else if (!bus_mbox_we)
         mb_we = 1'b0;
   end

   // Deferred software write; a second deferral overwrites it
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         pend_v    <= 1'b0;
         pend_addr <= 11'h000;
         pend_data <= 16'h0000;
      end
      else if (bus_mbox_we && (rx_we || pend_v))
      begin
         pend_v    <= 1'b1;
         pend_addr <= mbox_idx(ADDR_I);
         pend_data <= WR_DATA_I;
      end
      else if (!rx_we)
         pend_v <= 1'b0;
   end

   // Mailbox storage, no reset on data
   always_ff @(posedge CLK_I)
   begin
      if (mb_we)
         mbox[mb_addr] <= mb_data;
   end

   // ***********************************
   // Peer presence
   // ***********************************
   // Heard sets flag and restarts age; set wins over timeout
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         active <= 16'h0000;
         for (int i = 0; i < peer_xchg_pkg::FLAG_NODES; i++)
            age[i] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < peer_xchg_pkg::FLAG_NODES; i++)
         begin
            if (rx_we && RX_LAST_I && RX_HDR_I.node == 8'(i + 1))
            begin
               active[i] <= 1'b1;
               age[i]    <= 16'h0000;
            end
            else if (ms_tick && active[i])
            begin
               age[i] <= age[i] + 16'h0001;
               if (age[i] + 16'h0001 >= interval * peer_xchg_pkg::LOSS_INTERVALS
                   || !enable)
                  active[i] <= 1'b0;
            end
         end
      end
   end

   // ***********************************
   // Statistics
   // ***********************************
   // Frames sent and frames accepted
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         pkt_tx <= 16'h0000;
         pkt_rx <= 16'h0000;
      end
      else
      begin
         if (tx_start)
            pkt_tx <= pkt_tx + 16'h0001;
         if (rx_we && RX_LAST_I)
            pkt_rx <= pkt_rx + 16'h0001;
      end
   end

   // Collisions, and own frames that met one
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         coll        <= 16'h0000;
         coll_frames <= 16'h0000;
         tx_hit      <= 1'b0;
      end
      else
      begin
         if (COLLISION_I)
            coll <= coll + 16'h0001;
         if (tx_start)
            tx_hit <= 1'b0;
         else if (COLLISION_I && TX_VALID_O && !tx_hit)
         begin
            tx_hit      <= 1'b1;
            coll_frames <= coll_frames + 16'h0001;
         end
      end
   end

   // ***********************************
   // Checks
   // ***********************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   // Judged at frame start; a frame already under way may finish after a disable
   AST_LISTEN_SILENT: assert property ($rose(TX_VALID_O) |-> $past(enable)
                                       && $past(own_node) != 16'h0000)
      else $error("transmit while listen-only or disabled");
   AST_SLOT: assert property (tx_start |-> ms_count == slot_ms && ms_tick)
      else $error("broadcast outside own slot");
   AST_LEN: assert property (tx_fire && TX_LAST_O |-> tx_idx == TX_HDR_O.count - 8'h01
                             && TX_HDR_O.count <= peer_xchg_pkg::TX_LEN_MAX)
      else $error("frame length wrong");
   AST_HDR: assert property (tx_start |=> TX_HDR_O.dest == $past(dest_start)
                             && TX_HDR_O.count == $past(tx_length[7:0]))
      else $error("header not taken from setup");
   AST_BASE: assert property (tx_start |=> tx_base == $past(mbox_idx(tx_block_start)))
      else $error("transmit base wrong");
   AST_IGNORE: assert property (!enable && RX_VALID_I |=> $stable(pkt_rx))
      else $error("disabled node accepted broadcast");
   // The stored word itself, so a software write cannot displace a peer beat
   AST_PRIO: assert property (rx_we |=> mbox[$past(rx_addr)] == $past(RX_DATA_I))
      else $error("peer write lost priority");
   AST_ACTIVE: assert property (rx_we && RX_LAST_I && RX_HDR_I.node == 8'h02
                                |=> active[1])
      else $error("heard peer not flagged");
   AST_PKT: assert property (tx_start |=> pkt_tx == $past(pkt_tx) + 16'h0001)
      else $error("transmit counter missed");
   AST_COLL: assert property (COLLISION_I |=> coll == $past(coll) + 16'h0001)
      else $error("collision not counted");

   COV_SEND: cover property (tx_fire && TX_LAST_O);
   COV_RX: cover property (rx_we && RX_LAST_I);
   COV_DEFER: cover property (bus_mbox_we && rx_we);
   COV_LOSS: cover property (active[0] ##1 !active[0]);

endmodule
`default_nettype wire

// [rtl/peer_xchg_pkg.sv]
// Function
// - Broadcast 1 to 128 registers per node
// - One multicast packet updates all peers
// - Peer node total sets slot spacing
// - Own node number from setup register
// - Transmit block starts at configured index
// - Broadcast carries configured register count
// - Receivers store at sender's destination index
// - Update interval configured in milliseconds
// - Sharing runs only with enable bit set
// - Active bitmap flags nodes one to sixteen
// - Silent peer's active flag gets cleared
// - Peer loss leaves own timing unchanged
// - Broadcast falls inside own time slot
// - Interval spans consecutive own broadcasts
// - No acknowledgement for received broadcasts
// - Peer traffic beats other mailbox accesses
// - Node number zero means listen only
// - Disabled node ignores all peer broadcasts
// - Collision statistics readable in two registers
// - Packet counters readable in two registers
`default_nettype none
package peer_xchg_pkg;

   // ***********************************
   // Register offsets
   // ***********************************
   localparam logic [15:0] ADDR_PKT_A      = 16'h0810;
   localparam logic [15:0] ADDR_PKT_B      = 16'h0811;
   localparam logic [15:0] ADDR_COLL_A     = 16'h0812;
   localparam logic [15:0] ADDR_COLL_B     = 16'h0813;
   localparam logic [15:0] ADDR_ACTIVE     = 16'h0CE7;
   localparam logic [15:0] ADDR_INTERVAL   = 16'h1F4B;
   localparam logic [15:0] ADDR_OWN_NODE   = 16'h1F4C;
   localparam logic [15:0] ADDR_TX_START   = 16'h1F4D;
   localparam logic [15:0] ADDR_NODE_TOTAL = 16'h1F5A;
   localparam logic [15:0] ADDR_TX_LENGTH  = 16'h1F5B;
   localparam logic [15:0] ADDR_DEST_START = 16'h1F5C;
   localparam logic [15:0] ADDR_FEATURE    = 16'h1F5E;
   localparam logic [15:0] MBOX_FIRST      = 16'h0001;
   localparam logic [15:0] MBOX_LAST       = 16'h0800;

   // ***********************************
   // Fields, limits and reset values
   // ***********************************
   localparam int          ENABLE_BIT     = 6;
   localparam logic [15:0] REG_RESET      = 16'h0000;
   localparam logic [7:0]  TX_LEN_MAX     = 8'h80;
   localparam int          FLAG_NODES     = 16;
   localparam logic [15:0] LOSS_INTERVALS = 16'h0003;

   // ***********************************
   // Timing
   // ***********************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam int TICK_W        = 17;

   // ***********************************
   // Types
   // ***********************************
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01
   } tx_state_t;

   typedef struct packed {
      logic [7:0]  node;
      logic [15:0] dest;
      logic [7:0]  count;
   } peer_hdr_t;

endpackage
`default_nettype wire
